// *** lmf_pkg.sv ***
// lmf_pkg: constants and types shared by the load miss file design
// assumes one processor clock and 43-bit physical load addresses
package lmf_pkg;
   localparam int unsigned LD_ENTRIES = 6;
   localparam int unsigned IF_ENTRIES = 4;
   localparam int unsigned WB_ENTRIES = 6;
   localparam int unsigned QW_PER_BLK = 4;
   localparam int unsigned AW = 43;
   localparam int unsigned BLK_LO = 5;
   localparam int unsigned BW = AW - BLK_LO;
   localparam int unsigned QW_LO = 3;
   localparam int unsigned NC_BIT = 39;
   localparam int unsigned LAT_HI = 12;
   localparam int unsigned LAT_LO = 2;
   localparam int unsigned MODE_W = 8;
   localparam int unsigned MODE_NO_MERGE = 0;
   localparam int unsigned MODE_NC_NO_MERGE = 3;
   localparam int unsigned QW_W = 64;
   localparam int unsigned FILL_W = 2 * QW_W;
   localparam int unsigned REG_W = 5;
   localparam int unsigned DEST_DEPTH = LD_ENTRIES * QW_PER_BLK;

   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_QUAD} lmf_size_e;
   typedef logic [2:0] lmf_id_t;
   typedef logic [4:0] lmf_slot_t;
   typedef logic [BW-1:0] lmf_blk_t;
   // destination of one recorded quadword miss
   typedef struct packed {
      logic [REG_W-1:0] rnum;
      logic fp;
      lmf_size_e size;
      logic [2:0] off;
   } lmf_dest_s;
endpackage : lmf_pkg

// *** lmf_match.sv ***
// lmf_match: compares one load address against all miss entries
// assumes entry state comes from flops in the same clock domain
module lmf_match import lmf_pkg::*; (
   input wire logic [AW-1:0] addr,
   input wire logic [LD_ENTRIES-1:0] e_valid,
   input wire lmf_blk_t [LD_ENTRIES-1:0] e_blk,
   input wire logic [LD_ENTRIES-1:0][QW_PER_BLK-1:0] e_qw,
   output wire logic [LD_ENTRIES-1:0] blk_hit,
   output wire logic [LD_ENTRIES-1:0] qw_hit
);
   generate
      for (genvar i = 0; i < LD_ENTRIES; i++) begin : g_ent
         assign blk_hit[i] = e_valid[i] & (e_blk[i] == addr[AW-1:BLK_LO]);
         assign qw_hit[i] = blk_hit[i] & e_qw[i][addr[BLK_LO-1:QW_LO]];
      end
   endgenerate
endmodule : lmf_match

// *** lmf_dest_mem.sv ***
// lmf_dest_mem: per-quadword destination records, two writes, two reads
// assumes both write ports never name the same slot in one cycle
module lmf_dest_mem import lmf_pkg::*; (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic we_a,
   input wire lmf_slot_t addr_a,
   input wire lmf_dest_s wdata_a,
   input wire logic we_b,
   input wire lmf_slot_t addr_b,
   input wire lmf_dest_s wdata_b,
   input wire lmf_slot_t raddr_c,
   input wire lmf_slot_t raddr_d,
   output lmf_dest_s rdata_c,
   output lmf_dest_s rdata_d
);
   lmf_dest_s mem [DEST_DEPTH];

   generate
      for (genvar i = 0; i < DEST_DEPTH; i++) begin : g_slot
         always_ff @(posedge clock) begin
            if (we_b && addr_b == lmf_slot_t'(i))
               mem[i] <= wdata_b;
            else if (we_a && addr_a == lmf_slot_t'(i))
               mem[i] <= wdata_a;
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_c <= '0;
         rdata_d <= '0;
      end else begin
         rdata_c <= mem[raddr_c];
         rdata_d <= mem[raddr_d];
      end
   end
endmodule : lmf_dest_mem

// *** lmf_miss_file.sv ***
// lmf_miss_file: load miss tracking, merging, replay traps and fills
// assumes all partners share this clock
module lmf_miss_file import lmf_pkg::*; (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [MODE_W-1:0] miss_file_mode,
   input wire logic p0_ld_valid,
   input wire logic [AW-1:0] p0_ld_addr,
   input wire lmf_size_e p0_ld_size,
   input wire logic p0_ld_locked,
   input wire logic p0_ld_hit,
   input wire logic [REG_W-1:0] p0_ld_reg,
   input wire logic p0_ld_float,
   input wire logic p0_wb_conflict,
   input wire logic p1_ld_valid,
   input wire logic [AW-1:0] p1_ld_addr,
   input wire lmf_size_e p1_ld_size,
   input wire logic p1_ld_locked,
   input wire logic p1_ld_hit,
   input wire logic [REG_W-1:0] p1_ld_reg,
   input wire logic p1_ld_float,
   input wire logic p1_wb_conflict,
   input wire logic st_valid,
   input wire logic [AW-1:0] st_addr,
   input wire logic st_hit,
   input wire logic [2:0] wb_alloc_count,
   input wire logic cons_valid,
   input wire logic cons_pipe,
   input wire logic cons_same_cycle,
   input wire logic if_req_valid,
   input wire lmf_blk_t if_req_addr,
   input wire logic rd_req_ready,
   input wire logic fill_valid,
   input wire logic fill_ifetch,
   input wire lmf_id_t fill_id,
   input wire logic fill_second,
   input wire logic [FILL_W-1:0] fill_data,
   input wire logic fill_bubble_req,
   output logic p0_trap,
   output logic p1_trap,
   output logic st_trap,
   output logic cons_trap,
   output logic mem_issue_halt,
   output logic if_req_ready,
   output logic rd_req_valid,
   output logic rd_req_ifetch,
   output lmf_id_t rd_req_id,
   output lmf_blk_t rd_req_block,
   output logic [QW_PER_BLK-1:0] rd_req_qw_mask,
   output logic rd_req_nc,
   output logic bub_no_store,
   output logic bub_no_issue,
   output logic bub_no_mem,
   output logic rf_we0,
   output logic rf_we1,
   output logic rf_float0,
   output logic rf_float1,
   output logic [REG_W-1:0] rf_reg0,
   output logic [REG_W-1:0] rf_reg1,
   output logic [QW_W-1:0] rf_data0,
   output logic [QW_W-1:0] rf_data1
);
   typedef logic [LD_ENTRIES-1:0] vec_t;

   function automatic lmf_id_t first_set(input vec_t v);
      first_set = '0;
      for (int i = LD_ENTRIES - 1; i >= 0; i--)
         if (v[i]) first_set = lmf_id_t'(i);
   endfunction : first_set

   function automatic vec_t onehot(input lmf_id_t id);
      onehot = '0;
      onehot[id] = 1'b1;
   endfunction : onehot

   function automatic logic [QW_W-1:0] fmt(input logic [QW_W-1:0] q,
                                           input lmf_dest_s d);
      logic [QW_W-1:0] s;
      s = q >> {d.off, 3'h0};
      unique case (d.size)
         SZ_BYTE: fmt = {56'h0, s[7:0]};
         SZ_WORD: fmt = {48'h0, s[15:0]};
         SZ_LONG: fmt = d.fp ? {32'h0, s[31:0]} : {{32{s[31]}}, s[31:0]};
         SZ_QUAD: fmt = s;
      endcase
   endfunction : fmt

   ////////////////////////////////////////////////////////////////////////
   // entry state
   vec_t e_valid, e_nomerge, e_pend, e_locked;
   vec_t next_valid, next_nomerge, next_pend, next_locked;
   lmf_blk_t [LD_ENTRIES-1:0] e_blk, next_blk;
   logic [LD_ENTRIES-1:0][QW_PER_BLK-1:0] e_qw, next_qw;
   logic [IF_ENTRIES-1:0] if_valid, if_pend, next_if_valid, next_if_pend;
   lmf_blk_t [IF_ENTRIES-1:0] if_blk, next_if_blk;
   logic st_q_hit;
   logic [LAT_HI:LAT_LO] st_q_lat;
   logic [1:0] miss_q;

   ////////////////////////////////////////////////////////////////////////
   // hazards and merging
   vec_t bh0, qh0, bh1, qh1, ok0, ok1, fill_mask, nc_block;
   logic no_merge, nc_no_merge, nc0, nc1, kind0, kind1, miss0, miss1;
   logic full0, full1, lat0, lat1, trap0, trap1, go0, go1;
   logic merge0, merge1, alloc0, alloc1, s01, q01, okp, blk1;
   logic pend_any, if_pend_any, slot_free, byp0, byp1, fill_ld;
   logic [2:0] cnt;
   lmf_id_t free0, free1, tgt0, tgt1, sel, if_sel, if_free;
   logic [1:0] qw0, qw1;

   lmf_match u_match0 (.addr(p0_ld_addr), .e_valid(e_valid), .e_blk(e_blk),
      .e_qw(e_qw), .blk_hit(bh0), .qw_hit(qh0));
   lmf_match u_match1 (.addr(p1_ld_addr), .e_valid(e_valid), .e_blk(e_blk),
      .e_qw(e_qw), .blk_hit(bh1), .qw_hit(qh1));

   assign no_merge = miss_file_mode[MODE_NO_MERGE];
   assign nc_no_merge = miss_file_mode[MODE_NC_NO_MERGE];
   assign nc0 = p0_ld_addr[NC_BIT];
   assign nc1 = p1_ld_addr[NC_BIT];
   assign qw0 = p0_ld_addr[BLK_LO-1:QW_LO];
   assign qw1 = p1_ld_addr[BLK_LO-1:QW_LO];
   // which loads may merge at all
   assign kind0 = ~no_merge & ~p0_ld_locked & (~nc0 | (~nc_no_merge
      & (p0_ld_size == SZ_QUAD)));
   assign kind1 = ~no_merge & ~p1_ld_locked & (~nc1 | (~nc_no_merge
      & (p1_ld_size == SZ_QUAD)));
   assign fill_ld = fill_valid & ~fill_ifetch;
   assign fill_mask = fill_ld ? onehot(fill_id) : '0;
   assign pend_any = |e_pend;
   assign sel = first_set(e_pend);
   assign slot_free = ~rd_req_valid | rd_req_ready;
   // nc entry closes when offered
   assign nc_block = (rd_req_valid & ~rd_req_ifetch ? onehot(rd_req_id)
      : '0) | (slot_free & pend_any ? onehot(sel) : '0);
   assign ok0 = bh0 & ~qh0 & ~e_nomerge & ~fill_mask
      & (nc0 ? ~nc_block : '1) & {LD_ENTRIES{kind0}};
   assign ok1 = bh1 & ~qh1 & ~e_nomerge & ~fill_mask
      & (nc1 ? ~nc_block : '1) & {LD_ENTRIES{kind1}};
   assign cnt = 3'($countones(e_valid));
   assign full0 = cnt == 3'(LD_ENTRIES);
   assign full1 = cnt >= 3'(LD_ENTRIES - 1);
   assign lat0 = st_q_hit & (st_q_lat == p0_ld_addr[LAT_HI:LAT_LO]);
   assign lat1 = st_q_hit & (st_q_lat == p1_ld_addr[LAT_HI:LAT_LO]);
   assign miss0 = p0_ld_valid & ~p0_ld_hit;
   assign miss1 = p1_ld_valid & ~p1_ld_hit;
   assign trap0 = p0_ld_valid & (full0 | (|qh0) | lat0
      | (miss0 & (p0_wb_conflict
      | ((|bh0) & ~(|ok0) & ~nc0 & ~p0_ld_locked))));
   assign go0 = miss0 & ~trap0;
   assign merge0 = go0 & (|ok0);
   assign alloc0 = go0 & ~(|ok0);
   assign free0 = first_set(~e_valid);
   assign tgt0 = merge0 ? first_set(ok0) : free0;
   // pipe one sees pipe zero first
   assign s01 = p0_ld_addr[AW-1:BLK_LO] == p1_ld_addr[AW-1:BLK_LO];
   assign q01 = s01 & (qw0 == qw1);
   assign okp = alloc0 & s01 & ~q01 & kind0 & kind1;
   assign blk1 = (|bh1) | (go0 & s01);
   assign trap1 = p1_ld_valid & (trap0 | full1 | (|qh1) | (go0 & q01)
      | lat1 | (miss1 & (p1_wb_conflict
      | (blk1 & ~(|ok1) & ~okp & ~nc1 & ~p1_ld_locked))));
   assign go1 = miss1 & ~trap1;
   assign merge1 = go1 & ((|ok1) | okp);
   assign alloc1 = go1 & ~((|ok1) | okp);
   assign free1 = first_set(~e_valid & (alloc0 ? ~onehot(free0) : '1));
   assign tgt1 = okp ? free0 : ((|ok1) ? first_set(ok1) : free1);
   assign byp0 = alloc0 & ~pend_any & slot_free;
   assign byp1 = alloc1 & ~p0_ld_valid & ~pend_any & slot_free;
   assign if_pend_any = |if_pend;
   assign if_sel = first_set(vec_t'(if_pend));
   assign if_free = first_set(vec_t'(~if_valid));

   ////////////////////////////////////////////////////////////////////////
   // request slot, loads before fetches
   logic next_rd_valid, next_rd_ifetch, next_rd_nc, take_pend, take_if;
   lmf_id_t next_rd_id;
   lmf_blk_t next_rd_block;
   logic [QW_PER_BLK-1:0] next_rd_mask;

   always_comb begin
      next_rd_valid = rd_req_valid & ~rd_req_ready;
      next_rd_ifetch = rd_req_ifetch;
      next_rd_id = rd_req_id;
      next_rd_block = rd_req_block;
      next_rd_mask = rd_req_qw_mask;
      next_rd_nc = rd_req_nc;
      take_pend = 1'b0;
      take_if = 1'b0;
      if (slot_free) begin
         if (byp0) begin
            next_rd_valid = 1'b1;
            next_rd_ifetch = 1'b0;
            next_rd_id = free0;
            next_rd_block = p0_ld_addr[AW-1:BLK_LO];
            next_rd_mask = (4'h1 << qw0) | (okp ? 4'h1 << qw1 : 4'h0);
            next_rd_nc = nc0;
         end else if (byp1) begin
            next_rd_valid = 1'b1;
            next_rd_ifetch = 1'b0;
            next_rd_id = free1;
            next_rd_block = p1_ld_addr[AW-1:BLK_LO];
            next_rd_mask = 4'h1 << qw1;
            next_rd_nc = nc1;
         end else if (pend_any) begin
            take_pend = 1'b1;
            next_rd_valid = 1'b1;
            next_rd_ifetch = 1'b0;
            next_rd_id = sel;
            next_rd_block = e_blk[sel];
            next_rd_mask = e_qw[sel];
            next_rd_nc = e_blk[sel][NC_BIT-BLK_LO];
         end else if (if_pend_any) begin
            take_if = 1'b1;
            next_rd_valid = 1'b1;
            next_rd_ifetch = 1'b1;
            next_rd_id = if_sel;
            next_rd_block = if_blk[if_sel[1:0]];
            next_rd_mask = '1;
            next_rd_nc = if_blk[if_sel[1:0]][NC_BIT-BLK_LO];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // entry updates
   always_comb begin
      next_valid = e_valid;
      next_nomerge = e_nomerge;
      next_pend = e_pend;
      next_locked = e_locked;
      next_blk = e_blk;
      next_qw = e_qw;
      next_if_valid = if_valid;
      next_if_pend = if_pend;
      next_if_blk = if_blk;
      if (rd_req_valid && rd_req_ready && !rd_req_ifetch) begin
         next_locked[rd_req_id] = 1'b0;
         if (rd_req_nc)
            next_nomerge[rd_req_id] = 1'b1;
      end
      if (fill_ld) begin
         next_nomerge[fill_id] = 1'b1;
         if (fill_second)
            next_valid[fill_id] = 1'b0;
      end
      if (take_pend)
         next_pend[sel] = 1'b0;
      if (alloc0) begin
         next_valid[free0] = 1'b1;
         next_blk[free0] = p0_ld_addr[AW-1:BLK_LO];
         next_qw[free0] = 4'h1 << qw0;
         next_nomerge[free0] = ~kind0;
         next_pend[free0] = ~byp0;
         next_locked[free0] = p0_ld_locked;
      end else if (merge0) begin
         next_qw[tgt0][qw0] = 1'b1;
      end
      if (alloc1) begin
         next_valid[free1] = 1'b1;
         next_blk[free1] = p1_ld_addr[AW-1:BLK_LO];
         next_qw[free1] = 4'h1 << qw1;
         next_nomerge[free1] = ~kind1;
         next_pend[free1] = ~byp1;
         next_locked[free1] = p1_ld_locked;
      end else if (merge1) begin
         next_qw[tgt1][qw1] = 1'b1;
      end
      if (fill_valid && fill_ifetch && fill_second)
         next_if_valid[fill_id[1:0]] = 1'b0;
      if (take_if)
         next_if_pend[if_sel[1:0]] = 1'b0;
      if (if_req_valid && if_req_ready) begin
         next_if_valid[if_free[1:0]] = 1'b1;
         next_if_pend[if_free[1:0]] = 1'b1;
         next_if_blk[if_free[1:0]] = if_req_addr;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         e_valid <= '0;
         e_nomerge <= '0;
         e_pend <= '0;
         e_locked <= '0;
         e_blk <= '0;
         e_qw <= '0;
         if_valid <= '0;
         if_pend <= '0;
         if_blk <= '0;
      end else begin
         e_valid <= next_valid;
         e_nomerge <= next_nomerge;
         e_pend <= next_pend;
         e_locked <= next_locked;
         e_blk <= next_blk;
         e_qw <= next_qw;
         if_valid <= next_if_valid;
         if_pend <= next_if_pend;
         if_blk <= next_if_blk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // traps, request slot and bubbles
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         p0_trap <= 1'b0;
         p1_trap <= 1'b0;
         st_trap <= 1'b0;
         cons_trap <= 1'b0;
         st_q_hit <= 1'b0;
         st_q_lat <= '0;
         miss_q <= '0;
         mem_issue_halt <= 1'b0;
         if_req_ready <= 1'b0;
      end else begin
         p0_trap <= trap0;
         p1_trap <= trap1;
         st_trap <= st_valid & (wb_alloc_count == 3'(WB_ENTRIES));
         st_q_hit <= st_valid & st_hit;
         st_q_lat <= st_addr[LAT_HI:LAT_LO];
         miss_q <= {miss1, miss0};
         cons_trap <= cons_valid & (cons_same_cycle
            ? (cons_pipe ? miss1 : miss0) : miss_q[cons_pipe]);
         mem_issue_halt <= |next_locked;
         if_req_ready <= ~(&next_if_valid);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_req_valid <= 1'b0;
         rd_req_ifetch <= 1'b0;
         rd_req_id <= '0;
         rd_req_block <= '0;
         rd_req_qw_mask <= '0;
         rd_req_nc <= 1'b0;
         bub_no_store <= 1'b0;
         bub_no_issue <= 1'b0;
         bub_no_mem <= 1'b0;
      end else begin
         rd_req_valid <= next_rd_valid;
         rd_req_ifetch <= next_rd_ifetch;
         rd_req_id <= next_rd_id;
         rd_req_block <= next_rd_block;
         rd_req_qw_mask <= next_rd_mask;
         rd_req_nc <= next_rd_nc;
         bub_no_store <= fill_bubble_req;
         bub_no_issue <= bub_no_store;
         bub_no_mem <= bub_no_issue;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fill lookup, format, write
   lmf_dest_s dest_c, dest_d;
   logic [1:0] f1_we;
   logic [FILL_W-1:0] f1_data;
   lmf_slot_t slot_c, slot_d;

   assign slot_c = {fill_id, fill_second, 1'b0};
   assign slot_d = {fill_id, fill_second, 1'b1};

   lmf_dest_mem u_dest (.clock(clock), .rst_n(rst_n),
      .we_a(alloc0 | merge0), .addr_a({tgt0, qw0}),
      .wdata_a({p0_ld_reg, p0_ld_float, p0_ld_size, p0_ld_addr[2:0]}),
      .we_b(alloc1 | merge1), .addr_b({tgt1, qw1}),
      .wdata_b({p1_ld_reg, p1_ld_float, p1_ld_size, p1_ld_addr[2:0]}),
      .raddr_c(slot_c), .raddr_d(slot_d),
      .rdata_c(dest_c), .rdata_d(dest_d));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         f1_we <= '0;
         f1_data <= '0;
         rf_we0 <= 1'b0;
         rf_we1 <= 1'b0;
         rf_float0 <= 1'b0;
         rf_float1 <= 1'b0;
         rf_reg0 <= '0;
         rf_reg1 <= '0;
         rf_data0 <= '0;
         rf_data1 <= '0;
      end else begin
         f1_we[0] <= fill_ld & e_qw[fill_id][{fill_second, 1'b0}];
         f1_we[1] <= fill_ld & e_qw[fill_id][{fill_second, 1'b1}];
         f1_data <= fill_data;
         rf_we0 <= f1_we[0];
         rf_we1 <= f1_we[1];
         rf_float0 <= dest_c.fp;
         rf_float1 <= dest_d.fp;
         rf_reg0 <= dest_c.rnum;
         rf_reg1 <= dest_d.rnum;
         rf_data0 <= fmt(f1_data[QW_W-1:0], dest_c);
         rf_data1 <= fmt(f1_data[FILL_W-1:QW_W], dest_d);
      end
   end
endmodule : lmf_miss_file

// *** lmf_miss_file_assertions.sv ***
// lmf_miss_file_assertions: port-level checker for the load miss file
// assumes one clock domain, asynchronous active-low reset
module lmf_miss_file_chk import lmf_pkg::*; (
   input wire logic clock, rst_n, st_valid, st_hit, st_trap,
   input wire logic [AW-1:0] st_addr, p0_ld_addr,
   input wire logic [2:0] wb_alloc_count,
   input wire logic p0_ld_valid, p1_ld_valid, p0_trap, p1_trap,
   input wire logic fill_bubble_req, bub_no_store, bub_no_issue, bub_no_mem,
   input wire logic rd_req_valid, rd_req_ready, rd_req_ifetch,
   input wire lmf_blk_t rd_req_block,
   input wire logic [QW_PER_BLK-1:0] rd_req_qw_mask,
   input wire logic fill_valid, rf_we0
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_STORE_FULL: assert property (
      st_valid && wb_alloc_count == 3'h6 |=> st_trap)
      else $error("store kept, buffer full");
   AST_STORE_CAUSE: assert property (
      st_trap |-> $past(st_valid) && $past(wb_alloc_count) == 3'h6)
      else $error("store trap, buffer not full");
   AST_TRAP_CAUSE: assert property (
      p0_trap |-> $past(p0_ld_valid))
      else $error("pipe zero trap, no load");
   AST_P1_FOLLOWS: assert property (
      p0_trap && $past(p1_ld_valid) |-> p1_trap)
      else $error("pipe one kept after trap");
   AST_LOAD_STORE: assert property (
      st_valid && st_hit ##1
      p0_ld_valid && p0_ld_addr[12:2] == $past(st_addr[12:2]) |=> p0_trap)
      else $error("load after store kept");
   AST_BUBBLES: assert property (
      fill_bubble_req |=> bub_no_store ##1 bub_no_issue ##1 bub_no_mem)
      else $error("bubble train wrong");
   AST_REQ_HOLD: assert property (
      rd_req_valid && !rd_req_ready |=> rd_req_valid && $stable(rd_req_block))
      else $error("request dropped");
   AST_FETCH_MASK: assert property (
      rd_req_valid && rd_req_ifetch |-> rd_req_qw_mask == 4'hF)
      else $error("fetch mask not full");
   AST_FILL_WRITE: assert property (
      rf_we0 |-> $past(fill_valid, 2))
      else $error("register write without fill");
endmodule : lmf_miss_file_chk
bind lmf_miss_file lmf_miss_file_chk chk_u (.*);

// *** lmf_cbu_model.sv ***
// lmf_cbu_model: behavioural cache/bus unit facing the load miss file
// assumes fills in acceptance order; hold stalls
module lmf_cbu_model import lmf_pkg::*; (
   input wire logic clock, rst_n, hold, slow, rd_req_valid, rd_req_ifetch,
   input wire lmf_id_t rd_req_id,
   input wire lmf_blk_t rd_req_block,
   output logic rd_req_ready, fill_valid, fill_ifetch, fill_second,
   output logic fill_bubble_req,
   output lmf_id_t fill_id,
   output logic [FILL_W-1:0] fill_data
);
   timeunit 1ns;
   timeprecision 100ps;
   lmf_blk_t blk_of [16];
   logic [3:0] q[$];
   logic [3:0] cur;
   logic [1:0] ph;
   logic [31:0] lb;
   logic [FILL_W-1:0] pat;
   assign lb = blk_of[cur][31:0];
   assign pat = {lb, 30'h0, fill_second, 1'b1, lb, 30'h0, fill_second, 1'b0};
   // idle data shows inverse
   assign fill_data = fill_valid ? pat : ~pat;
   assign fill_ifetch = cur[3];
   assign fill_id = cur[2:0];
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_req_ready <= 1'b0;
         ph <= 2'h0;
         cur <= 4'h0;
         fill_valid <= 1'b0;
         fill_second <= 1'b0;
         fill_bubble_req <= 1'b0;
         q.delete();
      end else begin
         rd_req_ready <= slow ? ~rd_req_ready : 1'b1;
         if (rd_req_valid && rd_req_ready) begin
            blk_of[{rd_req_ifetch, rd_req_id}] <= rd_req_block;
            q.push_back({rd_req_ifetch, rd_req_id});
         end
         fill_bubble_req <= 1'b0;
         case (ph)
            2'h0: if (!hold && q.size() > 0) begin
               cur <= q.pop_front();
               fill_bubble_req <= 1'b1;
               ph <= 2'h1;
            end
            2'h1: begin
               fill_valid <= 1'b1;
               ph <= 2'h2;
            end
            2'h2: begin
               fill_second <= 1'b1;
               ph <= 2'h3;
            end
            default: begin
               fill_valid <= 1'b0;
               fill_second <= 1'b0;
               ph <= 2'h0;
            end
         endcase
      end
   end
endmodule : lmf_cbu_model

// *** lmf_miss_file_bench.sv ***
// lmf_miss_file_bench: self-checking bench of the load miss file
// assumes lmf_cbu_model far side; inputs 2 ns after edge
module lmf_miss_file_bench import lmf_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, rst_n, st_valid, st_hit, cons_valid, cons_pipe, hold, slow;
   logic cons_same_cycle, if_req_valid, rd_req_ready, fill_valid, fill_ifetch;
   logic fill_second, fill_bubble_req, p0_trap, p1_trap, st_trap, cons_trap;
   logic p0_ld_valid, p0_ld_locked, p0_ld_hit, p0_ld_float, p0_wb_conflict;
   logic p1_ld_valid, p1_ld_locked, p1_ld_hit, p1_ld_float, p1_wb_conflict;
   logic mem_issue_halt, if_req_ready, rd_req_valid, rd_req_ifetch, rd_req_nc;
   logic bub_no_store, bub_no_issue, bub_no_mem, rf_we0, rf_we1;
   logic rf_float0, rf_float1;
   logic [AW-1:0] p0_ld_addr, p1_ld_addr, st_addr, a;
   lmf_size_e p0_ld_size, p1_ld_size;
   logic [REG_W-1:0] p0_ld_reg, p1_ld_reg, rf_reg0, rf_reg1, rn;
   logic [MODE_W-1:0] miss_file_mode;
   logic [2:0] wb_alloc_count;
   lmf_blk_t if_req_addr, rd_req_block;
   lmf_id_t fill_id, rd_req_id;
   logic [FILL_W-1:0] fill_data;
   logic [QW_W-1:0] rf_data0, rf_data1;
   logic [QW_PER_BLK-1:0] rd_req_qw_mask;
   logic [31:0] sd;
   logic [64:0] exp_w [logic [4:0]];
   logic [63:0] xr[$];
   bit et [2];
   int n_fail, n_tests, i, k;

   lmf_miss_file dut_u (.*);
   lmf_cbu_model cbu_u (.*);

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [63:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   function automatic logic [42:0] ad(input bit nc, input logic [1:0] q);
      sd = {1'b0, sd[31:1]} ^ (sd[0] ? 32'hA300_0001 : 32'h0);
      return {3'h0, nc, 7'h0, sd[26:0], q, 3'h0};
   endfunction : ad

   task automatic ld(input bit p, input logic [42:0] ad_i, input lmf_size_e z,
                     input bit h, input bit lk, input bit t);
      rn++;
      et[p] = t;
      if (!h && !t)
         exp_w[rn] = {z != SZ_QUAD, ad_i[36:5], 30'h0, ad_i[4:3]};
      if (p) {p1_ld_valid, p1_ld_addr, p1_ld_size, p1_ld_hit, p1_ld_locked,
               p1_ld_reg} = {1'b1, ad_i, z, h, lk, rn};
      else {p0_ld_valid, p0_ld_addr, p0_ld_size, p0_ld_hit, p0_ld_locked,
            p0_ld_reg} = {1'b1, ad_i, z, h, lk, rn};
   endtask : ld

   task automatic req(input bit f, input logic [42:0] ad_i, logic [3:0] m);
      xr.push_back({21'h0, f, ad_i[42:5], m});
   endtask : req

   task automatic step;
      bit v0, v1, vc;
      {v0, v1, vc} = {p0_ld_valid, p1_ld_valid, cons_valid};
      @(posedge clock);
      #2;
      {p0_ld_valid, p1_ld_valid, st_valid, cons_valid} = 4'h0;
      {if_req_valid, p0_wb_conflict} = 2'h0;
      if (v0) chk("p0_trap", p0_trap, et[0]);
      if (v1) chk("p1_trap", p1_trap, et[1]);
      if (vc) chk("cons_trap", cons_trap, 1);
   endtask : step

   task automatic drain(input string nm);
      for (k = 0; k < 400 && (exp_w.size() + xr.size()) > 0; k++) step;
      repeat (8) step;
      chk("drained", exp_w.size() + xr.size(), 0);
      $display("test %s done", nm);
   endtask : drain

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input bit we, input logic [4:0] r, input logic [63:0] d);
      if (we && exp_w.exists(r)) begin
         if (!exp_w[r][64]) chk("rf_data", d, exp_w[r][63:0]);
         exp_w.delete(r);
      end else if (we) chk("rf_reg", r, 'x);
   endtask : wr

   always @(posedge clock) begin
      wr(rf_we0, rf_reg0, rf_data0);
      wr(rf_we1, rf_reg1, rf_data1);
      if (rd_req_valid && rd_req_ready)
         chk("request", {rd_req_ifetch, rd_req_block, rd_req_qw_mask},
             xr.size() ? xr.pop_front() : 'x);
   end

   initial begin
      #500000;
      n_fail++;
      conclude();
   end

   initial begin
      {rst_n, st_valid, st_hit, cons_valid, cons_pipe, hold, slow} = 7'h0;
      {cons_same_cycle, if_req_valid, p0_ld_valid, p1_ld_valid} = 4'h0;
      {p0_ld_locked, p0_ld_hit, p0_ld_float, p0_wb_conflict} = 4'h0;
      {p1_ld_locked, p1_ld_hit, p1_ld_float, p1_wb_conflict} = 4'h0;
      {p0_ld_addr, p1_ld_addr, st_addr, if_req_addr} = '0;
      {p0_ld_size, p1_ld_size, p0_ld_reg, p1_ld_reg, rn} = '0;
      {miss_file_mode, wb_alloc_count} = '0;
      sd = 32'hE4D4284E;
      repeat (12) @(posedge clock);
      #2 rst_n = 1'b1;
      for (i = 5; i < 7; i++) begin
         {st_valid, wb_alloc_count, st_addr} = {1'b1, 3'(i), ad(0, 2'h1)};
         step();
         chk("st_trap", st_trap, i == 6);
      end
      wb_alloc_count = 3'h0;
      a = ad(0, 2'h1);
      req(0, a, 4'h2);
      ld(0, a, SZ_QUAD, 0, 0, 0);
      step();
      chk("bypass", rd_req_valid, 1);
      drain("single");
      for (i = 0; i < 2; i++) begin
         miss_file_mode = MODE_W'(i);
         a = ad(0, 2'h0);
         req(0, a, i ? 4'h1 : 4'h5);
         ld(0, a, SZ_QUAD, 0, 0, 0);
         ld(1, a + 43'h10, SZ_QUAD, 0, 0, i);
         step();
         ld(0, a, SZ_LONG, 1, 0, 1);
         step();
         drain("merge");
      end
      for (i = 0; i < 3; i++) begin
         miss_file_mode = i == 1 ? 8'h08 : 8'h00;
         a = ad(1, 2'h0);
         if (i == 0) req(0, a, 4'h3);
         else begin
            req(0, a, 4'h1);
            req(0, a, 4'h2);
         end
         ld(0, a, i == 2 ? SZ_BYTE : SZ_QUAD, 0, 0, 0);
         ld(1, a + 43'h8, i == 2 ? SZ_BYTE : SZ_QUAD, 0, 0, 0);
         step();
         drain("noncacheable");
      end
      miss_file_mode = 8'h00;
      {hold, slow} = 2'h3;
      for (i = 0; i < 8; i++) begin
         a = ad(0, 2'h3);
         if (i < 5 || i == 6) req(0, a, 4'h8);
         ld(i == 5, a, SZ_QUAD, 0, 0, i == 5 || i == 7);
         if (i == 7) ld(1, ad(0, 2'h2), SZ_QUAD, 0, 0, 1);
         step();
      end
      hold = 1'b0;
      drain("full");
      slow = 1'b0;
      {st_valid, st_hit, st_addr} = {2'h3, ad(0, 2'h2)};
      step();
      a = ad(0, 2'h0);
      a[12:2] = st_addr[12:2];
      ld(0, a, SZ_LONG, 1, 0, 1);
      step();
      ld(0, ad(0, 2'h0), SZ_QUAD, 0, 0, 1);
      p0_wb_conflict = 1'b1;
      step();
      a = ad(0, 2'h2);
      req(0, a, 4'h4);
      ld(0, a, SZ_QUAD, 0, 0, 0);
      {cons_valid, cons_pipe, cons_same_cycle} = 3'h5;
      step();
      a = ad(0, 2'h1);
      req(0, a, 4'h2);
      ld(0, a, SZ_QUAD, 0, 1, 0);
      step();
      chk("halt", mem_issue_halt, 1);
      {if_req_valid, if_req_addr} = {1'b1, a[42:6], 1'b1};
      req(1, {if_req_addr, 5'h0}, 4'hF);
      step();
      drain("hazards");
      chk("halt", mem_issue_halt, 0);
      conclude();
   end
endmodule : lmf_miss_file_bench
